// ===== hw/wlan_spi_pkg.sv
// Shared constants, types and functions of the host serial slave port.
package wlan_spi_pkg;
  // Configuration byte at register 0x00 and status-control bits at 0x02.
  localparam int         CFG_WORD32    = 0;
  localparam int         CFG_BIG       = 1;
  localparam int         CFG_HS        = 4;
  localparam int         CFG_IRQ_POL   = 5;
  localparam int         CFG_WAKE      = 7;
  localparam logic [7:0] CFG0_RST      = 8'h30;
  localparam logic [7:0] CFG0_MASK     = 8'h33;
  localparam int         CFG2_STAT_EN  = 0;
  localparam int         CFG2_IRQ_W_ST = 1;
  localparam logic [1:0] CFG2_RST      = 2'h1;
  localparam logic [15:0] IRQ_EN_RST   = 16'hE0E7;
  // Register addresses of the standard function.
  localparam logic [16:0] REG_CFG      = 17'h0_0000;
  localparam logic [16:0] REG_IRQ      = 17'h0_0004;
  localparam logic [16:0] REG_STAT     = 17'h0_0008;
  localparam logic [16:0] REG_TEST     = 17'h0_0014;
  localparam logic [16:0] ADDR_STEP    = 17'h0_0004;
  localparam logic [31:0] TEST_PATTERN = 32'hFEED_BEAD;
  // Interrupt register bits.
  localparam int IRQ_DNA = 0;
  localparam int IRQ_UNF = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_PKT = 5;
  localparam int IRQ_F2  = 14;
  // Status word bits.
  localparam int ST_DNA     = 0;
  localparam int ST_UNF     = 1;
  localparam int ST_OVF     = 2;
  localparam int ST_F2_IRQ  = 3;
  localparam int ST_RX_RDY  = 5;
  localparam int ST_PKT     = 8;
  localparam int ST_LEN_LSB = 9;
  // Transfer limits and link rates.
  localparam int MAX_XFER_BYTES = 2048;
  localparam int SPI_MAX_MHZ    = 50;
  localparam int SD_HS_MHZ      = 50;
  localparam logic [9:0] BLK_STD = 10'h020;
  localparam logic [9:0] BLK_BP  = 10'h040;
  localparam logic [9:0] BLK_PKT = 10'h200;
  localparam logic [1:0] FN_STD  = 2'h0;
  localparam logic [1:0] FN_BP   = 2'h1;
  localparam logic [1:0] FN_PKT  = 2'h2;

  typedef struct packed {
    logic        wr;
    logic        incr;
    logic [1:0]  func;
    logic [16:0] addr;
    logic [10:0] len;
  } cmd_t;

  typedef struct packed {
    logic        f2_irq;
    logic        rx_rdy;
    logic        pkt;
    logic [10:0] len;
    logic        wr_rdy;
  } core_stat_t;

  // Everything that crosses from the reference domain into the link domain, except the read word rd_data_ff.
  typedef struct packed {
    logic        gen;
    logic        rd_tgl;
    logic        wack_tgl;
    core_stat_t  st;
    logic [7:0]  cfg0;
    logic [1:0]  cfg2;
    logic [15:0] irq;
    logic [15:0] en;
  } xr_t;

  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_DATA = 2'b01,
    PH_STAT = 2'b10,
    PH_DONE = 2'b11
  } phase_t;

  // Maps between shift order and the logical word; it is its own inverse.
  function automatic logic [31:0] reorder(input logic [31:0] w, input logic w32,
                                          input logic big);
    if (big)
      reorder = {w[7:0], w[15:8], w[23:16], w[31:24]};
    else if (w32)
      reorder = w;
    else
      reorder = {w[15:0], w[31:16]};
  endfunction

  function automatic logic [9:0] blk_limit(input logic [1:0] func);
    case (func)
      FN_STD:  blk_limit = BLK_STD;
      FN_BP:   blk_limit = BLK_BP;
      FN_PKT:  blk_limit = BLK_PKT;
      default: blk_limit = 10'h000;
    endcase
  endfunction
endpackage

// ===== hw/wlan_host_serial_slave_port.sv
// Device end of the shared host port: serial-peripheral slave and SD mode settings.
`timescale 1ns/1ns
module wlan_host_serial_slave_port #(
  parameter int MAX_WORDS = wlan_spi_pkg::MAX_XFER_BYTES / 4
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        mode_strap_i,
  input  wire logic        spi_clk_i,
  input  wire logic        shared_line_three_n_i,
  input  wire logic        host_serial_input_i,
  output logic             line0_o,
  output logic             line0_oe_o,
  output logic             shared_line_one_o,
  output logic             shared_line_one_oe_o,
  input  wire logic        oob_route_i,
  output logic             oob_irq_o,
  output logic             generic_mode_o,
  input  wire logic        sd_wide_i,
  input  wire logic        sd_hs_i,
  input  wire logic [1:0]  sd_func_i,
  input  wire logic [9:0]  sd_blk_len_i,
  output logic             sd_width4_o,
  output logic             sd_hs_o,
  output logic             sd_blk_ok_o,
  output logic             wake_o,
  input  wire logic        core_ready_i,
  output logic [31:0]      pkt_wr_data_o,
  output logic             pkt_wr_valid_o,
  input  wire logic        pkt_wr_ready_i,
  input  wire logic [31:0] pkt_rd_data_i,
  input  wire logic        pkt_rd_valid_i,
  output logic             pkt_rd_take_o,
  input  wire logic        f2_irq_i,
  input  wire logic        rx_ready_i,
  input  wire logic        pkt_avail_i,
  input  wire logic [10:0] pkt_len_i
);
  if (MAX_WORDS < 1 || MAX_WORDS > wlan_spi_pkg::MAX_XFER_BYTES / 4) begin : g_bad_words
    $error("MAX_WORDS must lie between 1 and 512");
  end

  // ----------------------------------------------------------------------
  // Reference-domain state
  // ----------------------------------------------------------------------
  logic                     strap_s1_ff, strap_s2_ff, gen_mode_ff;
  logic [7:0]               cfg0_ff;
  logic [1:0]               cfg2_ff;
  logic [15:0]              irq_en_ff;
  logic                     dna_ff, chip_act_ff, core_rdy_q_ff;
  logic [1:0]               uo_ff;
  logic                     rd_full_ff, rd_tgl_ff, wack_tgl_ff;
  logic [31:0]              rd_data_ff;
  wlan_spi_pkg::core_stat_t core_st_ff;
  logic [2:0]               l2r_s1_ff, l2r_s2_ff, l2r_s3_ff;
  logic [15:0]              irq_vec;
  logic                     wr_ev, take_ev, err_ev, line_on;

  // ----------------------------------------------------------------------
  // Link-domain state
  // ----------------------------------------------------------------------
  wlan_spi_pkg::xr_t    xr_s1_ff, xr_s2_ff;
  wlan_spi_pkg::phase_t ph_ff;
  wlan_spi_pkg::cmd_t   cmd_ff, rx_cmd;
  logic [4:0]           bit_ff;
  logic [31:0]          sh_ff, tx_ff, rx_word, rd_word, stat_word, nxt_sh;
  logic [16:0]          addr_ff, sel_addr;
  logic [9:0]           words_ff, nwords;
  logic [2:0]           err_ff, err_nxt, err_hold_ff;
  logic                 neg_ff, oe_ff;
  logic                 wr_tgl_ff, take_tgl_ff, err_tgl_ff;
  logic [31:0]          wr_word_ff;
  logic [1:0]           wr_func_ff, sel_func;
  logic [16:0]          wr_addr_ff;
  logic                 word_done, data_word, last_word, is_wr, load_rd, rd_ok;
  logic                 rd_avail, wr_pend, wr_go, take_go, ovf_now, dna_now, unf_now;

  // ----------------------------------------------------------------------
  // Mode strap and SD mode settings
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    strap_s1_ff <= mode_strap_i;
    strap_s2_ff <= strap_s1_ff;
    if (reset_i) begin
      gen_mode_ff <= strap_s2_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sd_width4_o    <= 1'b0;
      sd_hs_o        <= 1'b0;
      sd_blk_ok_o    <= 1'b0;
      generic_mode_o <= 1'b0;
    end else begin
      generic_mode_o <= gen_mode_ff;
      sd_width4_o    <= !gen_mode_ff && sd_wide_i;
      sd_hs_o        <= !gen_mode_ff && sd_wide_i && sd_hs_i;
      sd_blk_ok_o    <= !gen_mode_ff &&
                        (sd_blk_len_i <= wlan_spi_pkg::blk_limit(sd_func_i));
    end
  end

  // ----------------------------------------------------------------------
  // Link-to-reference event crossing
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      l2r_s1_ff <= 3'h0;
      l2r_s2_ff <= 3'h0;
      l2r_s3_ff <= 3'h0;
    end else begin
      l2r_s1_ff <= {wr_tgl_ff, take_tgl_ff, err_tgl_ff};
      l2r_s2_ff <= l2r_s1_ff;
      l2r_s3_ff <= l2r_s2_ff;
    end
  end

  assign wr_ev   = l2r_s2_ff[2] ^ l2r_s3_ff[2];
  assign take_ev = l2r_s2_ff[1] ^ l2r_s3_ff[1];
  assign err_ev  = l2r_s2_ff[0] ^ l2r_s3_ff[0];

  // ----------------------------------------------------------------------
  // Registers of the standard function and wake-up handshake
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg0_ff        <= wlan_spi_pkg::CFG0_RST;
      cfg2_ff        <= wlan_spi_pkg::CFG2_RST;
      irq_en_ff      <= wlan_spi_pkg::IRQ_EN_RST;
      wack_tgl_ff    <= 1'b0;
      wake_o         <= 1'b0;
      pkt_wr_data_o  <= 32'h0000_0000;
      pkt_wr_valid_o <= 1'b0;
    end else begin
      pkt_wr_valid_o <= 1'b0;
      if (wr_ev) begin
        wack_tgl_ff <= l2r_s2_ff[2];
        if (wr_func_ff != wlan_spi_pkg::FN_STD) begin
          pkt_wr_data_o  <= wr_word_ff;
          pkt_wr_valid_o <= 1'b1;
        end else if (wr_addr_ff == wlan_spi_pkg::REG_CFG) begin
          cfg0_ff <= wr_word_ff[7:0] & wlan_spi_pkg::CFG0_MASK;
          cfg2_ff <= wr_word_ff[17:16];
          if (wr_word_ff[wlan_spi_pkg::CFG_WAKE]) begin
            wake_o <= 1'b1;
          end
        end else if (wr_addr_ff == wlan_spi_pkg::REG_IRQ) begin
          irq_en_ff <= wr_word_ff[31:16];
        end
      end
    end
  end

  // Interrupt flags; a hardware set in the clearing cycle wins.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dna_ff        <= 1'b0;
      uo_ff         <= 2'h0;
      chip_act_ff   <= 1'b0;
      core_rdy_q_ff <= 1'b0;
    end else begin
      core_rdy_q_ff <= core_ready_i;
      if (err_ev && err_hold_ff[0]) begin
        dna_ff <= 1'b1;
      end else if (wr_ev && wr_func_ff == wlan_spi_pkg::FN_STD &&
                   wr_addr_ff == wlan_spi_pkg::REG_IRQ && wr_word_ff[wlan_spi_pkg::IRQ_DNA]) begin
        dna_ff <= 1'b0;
      end
      if (err_ev) begin
        uo_ff <= err_hold_ff[2:1];
      end
      if (wake_o && core_ready_i && !core_rdy_q_ff) begin
        chip_act_ff <= 1'b1;
      end else if (wr_ev && wr_func_ff == wlan_spi_pkg::FN_STD &&
                   wr_addr_ff == wlan_spi_pkg::REG_IRQ && wr_word_ff[wlan_spi_pkg::IRQ_F2]) begin
        chip_act_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    irq_vec                        = 16'h0000;
    irq_vec[wlan_spi_pkg::IRQ_DNA] = dna_ff;
    irq_vec[wlan_spi_pkg::IRQ_UNF] = uo_ff[0];
    irq_vec[wlan_spi_pkg::IRQ_OVF] = uo_ff[1];
    irq_vec[wlan_spi_pkg::IRQ_PKT] = core_st_ff.pkt;
    irq_vec[wlan_spi_pkg::IRQ_F2]  = core_st_ff.f2_irq || chip_act_ff;
  end

  // Status reporting can stand in for interrupts unless told otherwise.
  assign line_on = (|(irq_vec & irq_en_ff) &&
                    (!cfg2_ff[wlan_spi_pkg::CFG2_STAT_EN] ||
                     cfg2_ff[wlan_spi_pkg::CFG2_IRQ_W_ST])) ||
                   (chip_act_ff && irq_en_ff[wlan_spi_pkg::IRQ_F2]);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      shared_line_one_o    <= 1'b0;
      shared_line_one_oe_o <= 1'b0;
      oob_irq_o            <= 1'b0;
      core_st_ff           <= '0;
    end else begin
      shared_line_one_o    <= ~(line_on ^ cfg0_ff[wlan_spi_pkg::CFG_IRQ_POL]);
      shared_line_one_oe_o <= gen_mode_ff;
      oob_irq_o            <= oob_route_i && line_on;
      core_st_ff           <= {f2_irq_i, rx_ready_i, pkt_avail_i, pkt_len_i, pkt_wr_ready_i};
    end
  end

  // One-word read slot; the link consumes it by toggling take.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_full_ff    <= 1'b0;
      rd_tgl_ff     <= 1'b0;
      rd_data_ff    <= 32'h0000_0000;
      pkt_rd_take_o <= 1'b0;
    end else begin
      pkt_rd_take_o <= 1'b0;
      if (take_ev) begin
        rd_full_ff <= 1'b0;
      end else if (!rd_full_ff && pkt_rd_valid_i) begin
        rd_full_ff    <= 1'b1;
        rd_tgl_ff     <= ~rd_tgl_ff;
        rd_data_ff    <= pkt_rd_data_i;
        pkt_rd_take_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reference-to-link level crossing
  // ----------------------------------------------------------------------
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      xr_s1_ff <= '0;
      xr_s2_ff <= '0;
    end else begin
      xr_s1_ff <= {gen_mode_ff, rd_tgl_ff, wack_tgl_ff, core_st_ff,
                   cfg0_ff, cfg2_ff, irq_vec, irq_en_ff};
      xr_s2_ff <= xr_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Link-domain decode
  // ----------------------------------------------------------------------
  assign nxt_sh    = {sh_ff[30:0], host_serial_input_i};
  assign word_done = (bit_ff == 5'h1F);
  assign rx_word   = wlan_spi_pkg::reorder(nxt_sh, xr_s2_ff.cfg0[wlan_spi_pkg::CFG_WORD32],
                                           xr_s2_ff.cfg0[wlan_spi_pkg::CFG_BIG]);
  assign rx_cmd    = wlan_spi_pkg::cmd_t'(rx_word);
  assign nwords    = (rx_cmd.len == 11'h000) ? 10'(MAX_WORDS) :
                     10'((12'(rx_cmd.len) + 12'h003) >> 2);
  assign data_word = word_done && ph_ff == wlan_spi_pkg::PH_DATA;
  assign last_word = data_word && words_ff == 10'h001;
  assign is_wr     = (ph_ff == wlan_spi_pkg::PH_CMD) ? rx_cmd.wr : cmd_ff.wr;
  assign sel_func  = (ph_ff == wlan_spi_pkg::PH_CMD) ? rx_cmd.func : cmd_ff.func;
  assign sel_addr  = (ph_ff == wlan_spi_pkg::PH_CMD) ? rx_cmd.addr : addr_ff;
  assign load_rd   = word_done && !is_wr && (ph_ff == wlan_spi_pkg::PH_CMD ||
                     (data_word && words_ff != 10'h001));
  assign rd_avail  = xr_s2_ff.rd_tgl != take_tgl_ff;
  assign wr_pend   = wr_tgl_ff != xr_s2_ff.wack_tgl;
  assign wr_go     = data_word && cmd_ff.wr && !wr_pend &&
                     (cmd_ff.func == wlan_spi_pkg::FN_STD || xr_s2_ff.st.wr_rdy);
  assign ovf_now   = data_word && cmd_ff.wr && !wr_go;
  assign dna_now   = load_rd && !rd_ok;
  assign unf_now   = dna_now && sel_func != wlan_spi_pkg::FN_STD;
  assign take_go   = load_rd && sel_func != wlan_spi_pkg::FN_STD && rd_avail;
  assign err_nxt   = err_ff | {ovf_now, unf_now, dna_now};

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (sel_func != wlan_spi_pkg::FN_STD) begin
      rd_ok   = rd_avail;
      rd_word = rd_avail ? rd_data_ff : 32'h0000_0000;
    end else begin
      case (sel_addr)
        wlan_spi_pkg::REG_CFG:  rd_word = {14'h0000, xr_s2_ff.cfg2, 8'h00, xr_s2_ff.cfg0};
        wlan_spi_pkg::REG_IRQ:  rd_word = {xr_s2_ff.en, xr_s2_ff.irq};
        wlan_spi_pkg::REG_STAT: rd_word = stat_word;
        wlan_spi_pkg::REG_TEST: rd_word = wlan_spi_pkg::TEST_PATTERN;
        default:                rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    stat_word                                = 32'h0000_0000;
    stat_word[wlan_spi_pkg::ST_DNA]          = err_nxt[0];
    stat_word[wlan_spi_pkg::ST_UNF]          = err_nxt[1];
    stat_word[wlan_spi_pkg::ST_OVF]          = err_nxt[2];
    stat_word[wlan_spi_pkg::ST_F2_IRQ]       = xr_s2_ff.st.f2_irq;
    stat_word[wlan_spi_pkg::ST_RX_RDY]       = xr_s2_ff.st.rx_rdy;
    stat_word[wlan_spi_pkg::ST_PKT]          = xr_s2_ff.st.pkt;
    stat_word[wlan_spi_pkg::ST_LEN_LSB +: 11] = xr_s2_ff.st.len;
  end

  // ----------------------------------------------------------------------
  // Link transaction sequencer, cleared whenever select is high
  // ----------------------------------------------------------------------
  always_ff @(posedge spi_clk_i or posedge shared_line_three_n_i) begin
    if (shared_line_three_n_i) begin
      bit_ff   <= 5'h00;
      sh_ff    <= 32'h0000_0000;
      ph_ff    <= wlan_spi_pkg::PH_CMD;
      cmd_ff   <= '0;
      addr_ff  <= 17'h0_0000;
      words_ff <= 10'h000;
      tx_ff    <= 32'h0000_0000;
      err_ff   <= 3'h0;
      oe_ff    <= 1'b0;
    end else begin
      bit_ff <= bit_ff + 5'h01;
      sh_ff  <= nxt_sh;
      oe_ff  <= xr_s2_ff.gen;
      err_ff <= err_nxt;
      tx_ff  <= {tx_ff[30:0], 1'b0};
      if (word_done) begin
        case (ph_ff)
          wlan_spi_pkg::PH_CMD: begin
            cmd_ff   <= rx_cmd;
            words_ff <= nwords;
            ph_ff    <= wlan_spi_pkg::PH_DATA;
            addr_ff  <= rx_cmd.wr ? rx_cmd.addr : rx_cmd.addr + wlan_spi_pkg::ADDR_STEP;
            tx_ff    <= rx_cmd.wr ? 32'h0000_0000 :
                        wlan_spi_pkg::reorder(rd_word, xr_s2_ff.cfg0[wlan_spi_pkg::CFG_WORD32],
                                              xr_s2_ff.cfg0[wlan_spi_pkg::CFG_BIG]);
          end
          wlan_spi_pkg::PH_DATA: begin
            words_ff <= words_ff - 10'h001;
            addr_ff  <= addr_ff + wlan_spi_pkg::ADDR_STEP;
            if (last_word) begin
              ph_ff <= wlan_spi_pkg::PH_STAT;
              tx_ff <= xr_s2_ff.cfg2[wlan_spi_pkg::CFG2_STAT_EN] ?
                       wlan_spi_pkg::reorder(stat_word, xr_s2_ff.cfg0[wlan_spi_pkg::CFG_WORD32],
                                             xr_s2_ff.cfg0[wlan_spi_pkg::CFG_BIG]) :
                       32'h0000_0000;
            end else if (!cmd_ff.wr) begin
              tx_ff <= wlan_spi_pkg::reorder(rd_word, xr_s2_ff.cfg0[wlan_spi_pkg::CFG_WORD32],
                                             xr_s2_ff.cfg0[wlan_spi_pkg::CFG_BIG]);
            end else begin
              tx_ff <= 32'h0000_0000;
            end
          end
          wlan_spi_pkg::PH_STAT: begin
            ph_ff <= wlan_spi_pkg::PH_DONE;
            tx_ff <= 32'h0000_0000;
          end
          default: begin
            ph_ff <= wlan_spi_pkg::PH_DONE;
            tx_ff <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Toggles and held words survive the select-driven clear.
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_tgl_ff   <= 1'b0;
      take_tgl_ff <= 1'b0;
      err_tgl_ff  <= 1'b0;
      err_hold_ff <= 3'h0;
      wr_word_ff  <= 32'h0000_0000;
      wr_func_ff  <= 2'h0;
      wr_addr_ff  <= 17'h0_0000;
    end else begin
      if (wr_go) begin
        wr_tgl_ff  <= ~wr_tgl_ff;
        wr_word_ff <= rx_word;
        wr_func_ff <= cmd_ff.func;
        wr_addr_ff <= addr_ff;
      end
      if (take_go) begin
        take_tgl_ff <= ~take_tgl_ff;
      end
      if (last_word) begin
        err_tgl_ff  <= ~err_tgl_ff;
        err_hold_ff <= err_nxt;
      end
    end
  end

  // Falling-edge copy used when the drive edge is the falling one.
  always_ff @(negedge spi_clk_i or posedge shared_line_three_n_i) begin
    if (shared_line_three_n_i) begin
      neg_ff <= 1'b0;
    end else begin
      neg_ff <= tx_ff[31];
    end
  end

  assign line0_o    = xr_s2_ff.cfg0[wlan_spi_pkg::CFG_HS] ? tx_ff[31] : neg_ff;
  assign line0_oe_o = oe_ff;
endmodule

// ===== tb/wlan_port_sva.sv
// Checker of the host serial slave port, bound to its top module.
`timescale 1ns/1ns
module wlan_port_sva (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       shared_line_three_n_i,
  input wire logic       line0_oe_o,
  input wire logic       generic_mode_o,
  input wire logic       shared_line_one_oe_o,
  input wire logic       sd_width4_o,
  input wire logic       sd_hs_o,
  input wire logic [1:0] sd_func_i,
  input wire logic [9:0] sd_blk_len_i,
  input wire logic       sd_blk_ok_o,
  input wire logic       oob_route_i,
  input wire logic       oob_irq_o,
  input wire logic       pkt_wr_valid_o,
  input wire logic       pkt_rd_take_o,
  input wire logic       pkt_rd_valid_i,
  input wire logic       wake_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_idle_undriven: assert property (shared_line_three_n_i && $past(shared_line_three_n_i)
    |-> !line0_oe_o) else $error("data line driven while deselected");
  a_mode_excl: assert property (sd_width4_o |-> !generic_mode_o)
    else $error("card width active in serial mode");
  a_hs_needs_wide: assert property (sd_hs_o |-> sd_width4_o)
    else $error("high speed without wide bus");
  a_irq_pin_on: assert property (generic_mode_o [*3] |-> shared_line_one_oe_o)
    else $error("interrupt line undriven in serial mode");
  a_blk_limit: assert property (sd_func_i == 2'h0 && sd_blk_len_i > 10'h020
    |=> !sd_blk_ok_o) else $error("block size over limit accepted");
  a_oob_routed: assert property (oob_irq_o |-> $past(oob_route_i))
    else $error("out of band interrupt without route");
  a_wr_pulse: assert property (pkt_wr_valid_o |=> !pkt_wr_valid_o)
    else $error("write strobe longer than a cycle");
  a_take_cause: assert property (pkt_rd_take_o |-> $past(pkt_rd_valid_i) ##1 !pkt_rd_take_o)
    else $error("read word taken without offer");
  a_wake_held: assert property (wake_o |=> wake_o)
    else $error("wake flag dropped");
endmodule
bind wlan_host_serial_slave_port wlan_port_sva wlan_port_sva_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .shared_line_three_n_i(shared_line_three_n_i),
  .line0_oe_o(line0_oe_o), .generic_mode_o(generic_mode_o),
  .shared_line_one_oe_o(shared_line_one_oe_o), .sd_width4_o(sd_width4_o), .sd_hs_o(sd_hs_o),
  .sd_func_i(sd_func_i), .sd_blk_len_i(sd_blk_len_i), .sd_blk_ok_o(sd_blk_ok_o),
  .oob_route_i(oob_route_i), .oob_irq_o(oob_irq_o), .pkt_wr_valid_o(pkt_wr_valid_o),
  .pkt_rd_take_o(pkt_rd_take_o), .pkt_rd_valid_i(pkt_rd_valid_i), .wake_o(wake_o));

// ===== tb/spi_host_model.sv
// Host side model: drives the serial clock, select and data, captures the reply.
`timescale 1ns/1ns
module spi_host_model (
  output logic      spi_clk_o,
  output logic      sel_n_o,
  output logic      mosi_o,
  input wire logic  line0_i
);
  initial begin
    spi_clk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Sends command, one data word and room for status; clock stands still outside the frame.
  task automatic xfer(input logic [31:0] c, input logic [31:0] d, output logic [31:0] rd,
                      output logic [31:0] st);
    logic [95:0] tx;
    logic [63:0] rx;
    tx = {c, d, 32'h0000_0000};
    rx = 64'h0000_0000_0000_0000;
    sel_n_o = 1'b0;
    for (int i = 95; i >= 0; i--) begin
      mosi_o = tx[i];
      #7;
      if (i < 64)
        rx = {rx[62:0], line0_i};
      spi_clk_o = 1'b1;
      #8 spi_clk_o = 1'b0;
    end
    #7 sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    rd = rx[63:32];
    st = rx[31:0];
  endtask
endmodule

// ===== tb/test_wlan_host_serial_slave_port.sv
// Self-checking bench of the host serial slave port.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module test_wlan_host_serial_slave_port;
  logic        ref_clk_i, reset_i, sclk, cs_n, di, line0, oe0, wr_valid, oob_route, rd_valid;
  logic        mode_strap, sd_wide, sd_hs, core_ready, wr_ready, f2_irq, irq_line, oob_irq, wake;
  logic [1:0]  sd_func;
  logic [9:0]  sd_blk_len;
  wire  [3:0]  sd_o;
  logic [31:0] wr_data, got_wr, rd, st;
  int          failures, checks, n_wr;
  wlan_host_serial_slave_port #(.MAX_WORDS(8)) wlan_host_serial_slave_port_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .mode_strap_i(mode_strap), .spi_clk_i(sclk),
    .shared_line_three_n_i(cs_n), .host_serial_input_i(di), .line0_o(line0),
    .line0_oe_o(oe0), .shared_line_one_o(irq_line), .shared_line_one_oe_o(),
    .oob_route_i(oob_route), .oob_irq_o(oob_irq), .generic_mode_o(sd_o[0]),
    .sd_wide_i(sd_wide), .sd_hs_i(sd_hs), .sd_func_i(sd_func), .sd_blk_len_i(sd_blk_len),
    .sd_width4_o(sd_o[3]), .sd_hs_o(sd_o[2]), .sd_blk_ok_o(sd_o[1]), .wake_o(wake),
    .core_ready_i(core_ready), .pkt_wr_data_o(wr_data), .pkt_wr_valid_o(wr_valid),
    .pkt_wr_ready_i(wr_ready), .pkt_rd_data_i(32'h1234_5678), .pkt_rd_valid_i(rd_valid),
    .pkt_rd_take_o(), .f2_irq_i(f2_irq), .rx_ready_i(1'b1), .pkt_avail_i(1'b1),
    .pkt_len_i(11'h040));
  // A released data line shows the inverse of the current line0 value to the host.
  spi_host_model spi_host_model_i (.spi_clk_o(sclk), .sel_n_o(cs_n), .mosi_o(di),
                                   .line0_i(oe0 ? line0 : ~line0));
  // Shift order of a word: 0 as is, 1 halves swapped, 2 bytes reversed.
  function automatic logic [31:0] sw(input logic [31:0] w, input logic [1:0] h);
    sw = h[1] ? {w[7:0], w[15:8], w[23:16], w[31:24]} :
         h[0] ? {w[15:0], w[31:16]} : w;
  endfunction
  task automatic frame(input logic [31:0] c, input logic [31:0] d, input logic [1:0] h);
    spi_host_model_i.xfer(sw(c, h), sw(d, h), rd, st);
    rd = sw(rd, h);
    st = sw(st, h);
    repeat (12) @(negedge ref_clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) if (wr_valid) begin
    got_wr <= wr_data;
    n_wr <= n_wr + 1;
  end
  initial begin
    #100000 failures++;
    stop_test();
  end
  initial begin
    {reset_i, mode_strap, sd_wide, sd_hs, wr_ready} = 5'h1F;
    {oob_route, rd_valid, core_ready, f2_irq, sd_func} = 6'h00;
    {sd_blk_len, failures, checks, n_wr} = {10'h040, 96'd0};
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    frame(32'h4000_A004, 32'h0000_0000, 2'h1);
    `CHK(rd, 32'hFEED_BEAD)
    `CHK(st, 32'h0000_8120)
    `CHK(oe0, 1'b0)
    `CHK(sd_o, 4'b0001)
    $display("test default word read done");
    frame(32'hC000_0004, 32'h0001_0031, 2'h1);
    frame(32'h4000_A004, 32'h0000_0000, 2'h0);
    `CHK(rd, 32'hFEED_BEAD)
    $display("test wide word read done");
    frame(32'hE000_0004, 32'hA5A5_0F0F, 2'h0);
    `CHK(n_wr, 1)
    `CHK(got_wr, 32'hA5A5_0F0F)
    $display("test packet write done");
    oob_route = 1'b1;
    frame(32'h6000_0004, 32'h0000_0000, 2'h0);
    `CHK(rd, 32'h0000_0000)
    `CHK(st, 32'h0000_8123)
    frame(32'h4000_2004, 32'h0000_0000, 2'h0);
    `CHK(rd, 32'hE0E7_0023)
    rd_valid = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    frame(32'h6000_0004, 32'h0000_0000, 2'h0);
    `CHK(rd, 32'h1234_5678)
    wr_ready = 1'b0;
    frame(32'hE000_0004, 32'h1111_2222, 2'h0);
    `CHK(n_wr, 1)
    `CHK(st, 32'h0000_8124)
    $display("test packet read done");
    frame(32'hC000_0004, 32'h0001_00B1, 2'h0);
    `CHK(irq_line, 1'b0)
    core_ready = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    `CHK(wake, 1'b1)
    `CHK(irq_line, 1'b1)
    `CHK(oob_irq, 1'b1)
    $display("test wake up done");
    frame(32'hC000_0004, 32'h0001_0023, 2'h0);
    f2_irq = 1'b1;
    frame(32'h4000_A004, 32'h0000_0000, 2'h2);
    `CHK(rd, 32'hFEED_BEAD)
    `CHK(st, 32'h0000_8128)
    $display("test big endian falling edge done");
    {reset_i, mode_strap} = 2'b10;
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK(sd_o, 4'b1100)
    {sd_wide, sd_func} = 3'b001;
    repeat (2) @(negedge ref_clk_i);
    `CHK(sd_o, 4'b0010)
    $display("test card mode done");
    stop_test();
  end
endmodule
